// ---- verilog/qry_pkg.sv ----
// constants for the query table readout
package qry_pkg;
  localparam int ADDR_W = 23;
  localparam int DQ_W = 32;
  localparam int SYNC_W = ADDR_W + 2;
  localparam int BLK_W = 7;
  localparam int NUM_BLK = 128;
  localparam int OFF_W = 22;
  // command codes from the command decoder
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_SIG = 8'h90;
  localparam logic [7:0] CMD_READ_STAT = 8'h70;
  // table offsets
  localparam logic [OFF_W-1:0] OFF_MFR = 22'h000000;
  localparam logic [OFF_W-1:0] OFF_DEV = 22'h000001;
  localparam logic [OFF_W-1:0] OFF_STR_Q = 22'h000010;
  localparam logic [OFF_W-1:0] OFF_STR_R = 22'h000011;
  localparam logic [OFF_W-1:0] OFF_STR_Y = 22'h000012;
  localparam logic [OFF_W-1:0] OFF_CSID_LO = 22'h000013;
  localparam logic [OFF_W-1:0] OFF_CSID_HI = 22'h000014;
  localparam logic [OFF_W-1:0] OFF_PTR_LO = 22'h000015;
  localparam logic [OFF_W-1:0] OFF_PTR_HI = 22'h000016;
  localparam logic [OFF_W-1:0] OFF_ALT_FIRST = 22'h000017;
  localparam logic [OFF_W-1:0] OFF_ALT_LAST = 22'h00001a;
  localparam logic [OFF_W-1:0] OFF_SYSIF = 22'h00001b;
  localparam logic [OFF_W-1:0] OFF_GEOM = 22'h000027;
  // table data
  localparam logic [7:0] VAL_Q = 8'h51;
  localparam logic [7:0] VAL_R = 8'h52;
  localparam logic [7:0] VAL_Y = 8'h59;
  localparam logic [7:0] VAL_PTR_LO = 8'h31;
  localparam logic [7:0] VAL_ZERO = 8'h00;
  // block map: low word-address bits inside a block, per organisation
  localparam int BLK_LSB_X16 = 16;
  localparam int BLK_LSB_X32 = 15;
  localparam logic [15:0] BLK_STAT_OFS = 16'h0002;
  typedef enum logic [1:0] {
    ST_ARRAY = 2'b01,
    ST_QUERY = 2'b10
  } mode_t;
endpackage : qry_pkg

// ---- verilog/qry_readout.sv ----
// query-mode table readout of the flash interface
`timescale 1ns/1ps

// How it works
// - the query entry command moves the block into query mode, where reads return table data.
// - on the wide variant in x16, address bit 1 does not change the returned table data; it only selects block status reads.
// - x16 decodes word address bits 23..1, x32 decodes bits 23..2.
// - table bytes go on data lines 7..0; lines 15..8 are driven to zero, and lines 31..16 are too in x32.
// - data lines 31..16 are released whenever the organisation is x16.
// - identification sits at 00h/01h, the string at 10h; the interface (1Bh) and geometry (27h) offsets return zero.
// - offsets 10h, 11h and 12h return Q, R and Y.
// - offsets 13h and 14h return the command set code, low byte first.
// - offsets 15h and 16h return the extended table pointer 0031h then zero.
// - offsets 17h to 1Ah return zero, as no alternate algorithm exists.
// - a read at a block's start base plus two returns that block's status.
// - blocks are 10000h word addresses in x16 and 8000h in x32.
// - there is no byte-wide organisation.
module qry_readout
  import qry_pkg::*;
#(
  parameter bit WIDE_VARIANT = 1'b1,
  // identification values below are arbitrary
  parameter logic [7:0] MFR_CODE = 8'h5a,
  parameter logic [7:0] DEV_CODE = 8'hc3,
  parameter logic [15:0] CSID_CODE = 16'h00a5
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [ADDR_W:1] addr_pin,
  input wire logic rd_pin,
  input wire logic org_x32_pin,
  input wire logic [NUM_BLK-1:0] blk_lock,
  output logic query_mode_ff,
  output logic [DQ_W-1:0] dq_out_ff,
  output logic dq_oe_lo_ff,
  output logic dq_oe_hi_ff,
  output logic [BLK_W-1:0] blk_sel_ff
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] table_byte(input logic [OFF_W-1:0] off);
    logic [7:0] v;
    v = VAL_ZERO;
    case (off)
      OFF_MFR: v = MFR_CODE;
      OFF_DEV: v = DEV_CODE;
      OFF_STR_Q: v = VAL_Q;
      OFF_STR_R: v = VAL_R;
      OFF_STR_Y: v = VAL_Y;
      OFF_CSID_LO: v = CSID_CODE[7:0];
      OFF_CSID_HI: v = CSID_CODE[15:8];
      OFF_PTR_LO: v = VAL_PTR_LO;
      OFF_PTR_HI: v = VAL_ZERO;
      default: v = VAL_ZERO;
    endcase
    return v;
  endfunction : table_byte

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a bit moves once stages two and three agree
  logic [SYNC_W-1:0] s1_ff;
  logic [SYNC_W-1:0] s2_ff;
  logic [SYNC_W-1:0] s3_ff;
  logic [SYNC_W-1:0] stb_ff;
  wire [SYNC_W-1:0] pin_vec = {org_x32_pin, rd_pin, addr_pin};
  wire [SYNC_W-1:0] agree = ~(s2_ff ^ s3_ff);
  wire [SYNC_W-1:0] nxt_stb = (agree & s3_ff) | (~agree & stb_ff);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      stb_ff <= '0;
    end else begin
      s1_ff <= pin_vec;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      stb_ff <= nxt_stb;
    end
  end

  wire [ADDR_W:1] a_s = stb_ff[ADDR_W-1:0];
  wire rd_s = stb_ff[ADDR_W];
  // the narrow variant has no x32 organisation and never byte mode
  wire x32_s = stb_ff[ADDR_W+1] & WIDE_VARIANT;

  ////////////////////////////////////////////////////////////////////////
  // address decode
  wire [ADDR_W-1:0] waddr16 = a_s[ADDR_W:1];
  wire [OFF_W-1:0] waddr32 = a_s[ADDR_W:2];
  // wide x16: host doubles offsets, so bit 1 drops out
  wire [OFF_W-1:0] tbl_off = (x32_s | WIDE_VARIANT) ? waddr32 : waddr16[OFF_W-1:0];
  wire [BLK_W-1:0] blk16 = waddr16[ADDR_W-1:BLK_LSB_X16];
  wire [BLK_W-1:0] blk32 = waddr32[OFF_W-1:BLK_LSB_X32];
  wire [BLK_W-1:0] blk_idx = x32_s ? blk32 : blk16;
  wire hit16 = waddr16[BLK_LSB_X16-1:0] == BLK_STAT_OFS;
  wire hit32 = waddr32[BLK_LSB_X32-1:0] == BLK_STAT_OFS[BLK_LSB_X32-1:0];
  // in wide x16 the status read of block 0 shadows table offset 01h
  wire blk_hit = x32_s ? hit32 : hit16;
  wire [7:0] stat_byte = {7'h00, blk_lock[blk_idx]};
  wire [7:0] rd_byte = blk_hit ? stat_byte : table_byte(tbl_off);

  ////////////////////////////////////////////////////////////////////////
  // mode control
  mode_t st_ff;
  mode_t nxt_st;
  wire cmd_enter = cmd_valid & (cmd_code == CMD_QUERY);
  wire cmd_leave = cmd_valid & ((cmd_code == CMD_READ_ARRAY) |
                   (cmd_code == CMD_READ_SIG) | (cmd_code == CMD_READ_STAT));

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_ARRAY: if (cmd_enter) nxt_st = ST_QUERY;
      ST_QUERY: if (cmd_leave) nxt_st = ST_ARRAY;
      default: nxt_st = ST_ARRAY;
    endcase
  end

  wire in_q = (st_ff == ST_QUERY);
  wire drive = in_q & rd_s;
  // array data belongs to another block, so outside query mode we release
  wire [DQ_W-1:0] nxt_dq = drive ? {24'h000000, rd_byte} : '0;
  wire nxt_oe_hi = drive & x32_s;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= ST_ARRAY;
      query_mode_ff <= 1'b0;
      dq_out_ff <= '0;
      dq_oe_lo_ff <= 1'b0;
      dq_oe_hi_ff <= 1'b0;
      blk_sel_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      query_mode_ff <= (nxt_st == ST_QUERY);
      dq_out_ff <= nxt_dq;
      dq_oe_lo_ff <= drive;
      dq_oe_hi_ff <= nxt_oe_hi;
      blk_sel_ff <= blk_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_enter;
    @(posedge mclk) disable iff (!arst_n)
    cmd_enter |=> query_mode_ff && in_q;
  endproperty
  a_enter: assert property (p_enter) else $error("query entry missed");

  property p_hold;
    @(posedge mclk) disable iff (!arst_n)
    (in_q && !cmd_leave) |=> in_q;
  endproperty
  a_hold: assert property (p_hold) else $error("query mode dropped");

  property p_upper_zero;
    @(posedge mclk) disable iff (!arst_n)
    dq_oe_lo_ff |-> dq_out_ff[DQ_W-1:8] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper lines set");

  property p_hiz;
    @(posedge mclk) disable iff (!arst_n)
    dq_oe_hi_ff |-> $past(x32_s) && dq_oe_lo_ff;
  endproperty
  a_hiz: assert property (p_hiz) else $error("upper lines driven in x16");

  property p_str;
    @(posedge mclk) disable iff (!arst_n)
    (drive && !blk_hit && tbl_off == OFF_STR_Y) |=> dq_out_ff[7:0] == VAL_Y;
  endproperty
  a_str: assert property (p_str) else $error("string byte wrong");

  property p_ptr;
    @(posedge mclk) disable iff (!arst_n)
    (drive && !blk_hit && tbl_off == OFF_PTR_LO) |=> dq_out_ff == DQ_W'(VAL_PTR_LO);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer wrong");

  property p_alt;
    @(posedge mclk) disable iff (!arst_n)
    (drive && !blk_hit && tbl_off >= OFF_ALT_FIRST && tbl_off <= OFF_ALT_LAST)
      |=> dq_out_ff == '0;
  endproperty
  a_alt: assert property (p_alt) else $error("alternate entry not zero");

  property p_blk;
    @(posedge mclk) disable iff (!arst_n)
    (drive && blk_hit) |=> dq_out_ff == DQ_W'($past(blk_lock[a_s[ADDR_W:ADDR_W-BLK_W+1]]))
      && blk_sel_ff == $past(a_s[ADDR_W:ADDR_W-BLK_W+1]);
  endproperty
  a_blk: assert property (p_blk) else $error("block status wrong");

  property p_a1;
    @(posedge mclk) disable iff (!arst_n)
    (drive && !x32_s && WIDE_VARIANT && !blk_hit && $past(drive && !blk_hit && !x32_s)
      && a_s[ADDR_W:2] == $past(a_s[ADDR_W:2])) |=> dq_out_ff == $past(dq_out_ff);
  endproperty
  a_a1: assert property (p_a1) else $error("bit 1 changed data");

  property p_idle;
    @(posedge mclk) disable iff (!arst_n)
    !drive |=> !dq_oe_lo_ff && dq_out_ff == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("drive outside query read");

  property p_leave;
    @(posedge mclk) disable iff (!arst_n)
    (in_q && cmd_leave) |=> !query_mode_ff && !in_q;
  endproperty
  a_leave: assert property (p_leave) else $error("query mode kept after leave");

  property p_mirror;
    @(posedge mclk) disable iff (!arst_n)
    query_mode_ff == in_q;
  endproperty
  a_mirror: assert property (p_mirror) else $error("mode flag disagrees with state");

  property p_state_code;
    @(posedge mclk) disable iff (!arst_n)
    $onehot(st_ff);
  endproperty
  a_state_code: assert property (p_state_code) else $error("mode state not one-hot");

  property p_read_drive;
    @(posedge mclk) disable iff (!arst_n)
    drive |=> dq_oe_lo_ff;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("query read not driven");

  property p_wide_drive;
    @(posedge mclk) disable iff (!arst_n)
    (drive && x32_s) |=> dq_oe_hi_ff && dq_out_ff[DQ_W-1:16] == '0;
  endproperty
  a_wide_drive: assert property (p_wide_drive) else $error("upper half not zero");

  property p_mfr;
    @(posedge mclk) disable iff (!arst_n)
    (drive && !blk_hit && tbl_off == OFF_MFR) |=> dq_out_ff == DQ_W'(MFR_CODE);
  endproperty
  a_mfr: assert property (p_mfr) else $error("maker code wrong");

  property p_dev;
    @(posedge mclk) disable iff (!arst_n)
    (drive && !blk_hit && tbl_off == OFF_DEV) |=> dq_out_ff == DQ_W'(DEV_CODE);
  endproperty
  a_dev: assert property (p_dev) else $error("device code wrong");

  property p_str_q;
    @(posedge mclk) disable iff (!arst_n)
    (drive && !blk_hit && tbl_off == OFF_STR_Q) |=> dq_out_ff == DQ_W'(VAL_Q);
  endproperty
  a_str_q: assert property (p_str_q) else $error("first string byte wrong");

  property p_str_r;
    @(posedge mclk) disable iff (!arst_n)
    (drive && !blk_hit && tbl_off == OFF_STR_R) |=> dq_out_ff == DQ_W'(VAL_R);
  endproperty
  a_str_r: assert property (p_str_r) else $error("second string byte wrong");

  property p_csid_lo;
    @(posedge mclk) disable iff (!arst_n)
    (drive && !blk_hit && tbl_off == OFF_CSID_LO) |=> dq_out_ff == DQ_W'(CSID_CODE[7:0]);
  endproperty
  a_csid_lo: assert property (p_csid_lo) else $error("command set low byte wrong");

  property p_csid_hi;
    @(posedge mclk) disable iff (!arst_n)
    (drive && !blk_hit && tbl_off == OFF_CSID_HI) |=> dq_out_ff == DQ_W'(CSID_CODE[15:8]);
  endproperty
  a_csid_hi: assert property (p_csid_hi) else $error("command set high byte wrong");

  property p_ptr_hi;
    @(posedge mclk) disable iff (!arst_n)
    (drive && !blk_hit && tbl_off == OFF_PTR_HI) |=> dq_out_ff == '0;
  endproperty
  a_ptr_hi: assert property (p_ptr_hi) else $error("pointer high word not zero");

  property p_undef;
    @(posedge mclk) disable iff (!arst_n)
    (drive && !blk_hit && ((tbl_off > OFF_DEV && tbl_off < OFF_STR_Q) ||
      tbl_off > OFF_ALT_LAST)) |=> dq_out_ff == '0;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined offset not zero");

  property p_blk_map;
    @(posedge mclk) disable iff (!arst_n)
    1'b1 |=> blk_sel_ff == $past(a_s[ADDR_W:ADDR_W-BLK_W+1]);
  endproperty
  a_blk_map: assert property (p_blk_map) else $error("block index wrong");

  c_query_read: cover property (@(posedge mclk) disable iff (!arst_n)
    cmd_enter ##[1:20] drive);
  c_x32_read: cover property (@(posedge mclk) disable iff (!arst_n) dq_oe_hi_ff);
  c_blk_read: cover property (@(posedge mclk) disable iff (!arst_n) drive && blk_hit);
  c_leave: cover property (@(posedge mclk) disable iff (!arst_n) in_q && cmd_leave);
  c_a1_toggle: cover property (@(posedge mclk) disable iff (!arst_n)
    drive && !x32_s && $changed(a_s[1]));

endmodule : qry_readout

// ---- test/host_reader.sv ----
// host model that presents query offsets on the address pins
`timescale 1ns/1ps
module host_reader (
  input wire logic mclk,
  input wire logic go,
  input wire logic [21:0] off,
  input wire logic a1,
  output logic [23:1] addr_pin,
  output logic rd_pin
);
  initial begin
    addr_pin = '0;
    rd_pin = 1'b0;
  end
  // the offset lands on A23..A2, so the host doubles it; A1 is free
  always @(negedge mclk) begin
    if (go) begin
      addr_pin <= {off, a1};
      rd_pin <= 1'b1;
    end else begin
      // idle bus is not held: flip the lines so stale values never match
      addr_pin <= ~addr_pin;
      rd_pin <= 1'b0;
    end
  end
endmodule : host_reader

// ---- test/qry_readout_tb.sv ----
// self-checking bench for the query table readout
`timescale 1ns/1ps
module qry_readout_tb;
  import qry_pkg::*;
  typedef logic [31:0] row_t;
  logic mclk, arst_n, cmd_valid, org_x32_pin, go, a1, rd_pin;
  logic query_mode_ff, dq_oe_lo_ff, dq_oe_hi_ff;
  logic [7:0] cmd_code;
  logic [21:0] off;
  logic [ADDR_W:1] addr_pin;
  logic [NUM_BLK-1:0] blk_lock;
  logic [DQ_W-1:0] dq_out_ff;
  logic [BLK_W-1:0] blk_sel_ff;
  int errors, cmp_count;
  // row: org, offset, a1, expected byte; the two 12h rows differ only in a1
  row_t rows [14] = '{{1'b0, 22'h10, 1'b0, 8'h51}, {1'b1, 22'h11, 1'b0, 8'h52},
    {1'b0, 22'h12, 1'b0, 8'h59}, {1'b0, 22'h12, 1'b1, 8'h59}, {1'b1, 22'h13, 1'b0, 8'ha5},
    {1'b0, 22'h14, 1'b1, 8'h00}, {1'b1, 22'h15, 1'b0, 8'h31}, {1'b0, 22'h16, 1'b0, 8'h00},
    {1'b1, 22'h17, 1'b0, 8'h00}, {1'b0, 22'h1a, 1'b1, 8'h00}, {1'b1, 22'h1b, 1'b0, 8'h00},
    {1'b0, 22'h00, 1'b1, 8'h5a}, {1'b1, 22'h01, 1'b0, 8'hc3}, {1'b0, 22'h30, 1'b0, 8'h00}};
  logic [7:0] lv [3] = '{CMD_READ_ARRAY, CMD_READ_SIG, CMD_READ_STAT};

  qry_readout qry_readout_inst (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .addr_pin(addr_pin), .rd_pin(rd_pin), .org_x32_pin(org_x32_pin),
    .blk_lock(blk_lock), .query_mode_ff(query_mode_ff), .dq_out_ff(dq_out_ff),
    .dq_oe_lo_ff(dq_oe_lo_ff), .dq_oe_hi_ff(dq_oe_hi_ff), .blk_sel_ff(blk_sel_ff));
  host_reader host_reader_inst (.mclk(mclk), .go(go), .off(off), .a1(a1),
    .addr_pin(addr_pin), .rd_pin(rd_pin));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk_val
  task automatic chk_bit(string n, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %b got %b", n, e, g);
    end
  endtask : chk_bit
  task automatic send(logic [7:0] c);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_code = c;
    @(negedge mclk);
    cmd_valid = 1'b0;
    @(negedge mclk);
  endtask : send
  // eight cycles covers the five-edge synchroniser latency with margin
  task automatic rd_at(logic o, logic [21:0] f, logic b);
    @(negedge mclk);
    org_x32_pin = o;
    off <= f;
    a1 <= b;
    go <= 1'b1;
    repeat (8) @(negedge mclk);
  endtask : rd_at
  task automatic chk_rd(logic o, logic [7:0] d, logic oe);
    chk_val("dq", {24'h000000, d}, dq_out_ff);
    chk_bit("oe_lo", oe, dq_oe_lo_ff);
    chk_bit("oe_hi", o & oe, dq_oe_hi_ff);
  endtask : chk_rd
  task automatic conclude();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #100000;
    errors++;
    conclude();
  end
  initial begin
    errors = 0;
    cmp_count = 0;
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    org_x32_pin = 1'b0;
    go = 1'b0;
    off = '0;
    a1 = 1'b0;
    blk_lock = {1'b1, 126'h0, 1'b1};
    repeat (2) @(negedge mclk);
    chk_rd(1'b0, 8'h00, 1'b0);
    arst_n = 1'b1;
    rd_at(1'b1, 22'h10, 1'b0);
    chk_rd(1'b1, 8'h00, 1'b0);
    send(CMD_QUERY);
    chk_bit("qmode", 1'b1, query_mode_ff);
    foreach (rows[i]) begin
      rd_at(rows[i][31], rows[i][30:9], rows[i][8]);
      chk_rd(rows[i][31], rows[i][7:0], 1'b1);
    end
    rd_at(1'b0, 22'h000001, 1'b0);
    chk_rd(1'b0, 8'h01, 1'b1);
    chk_val("blk", 32'h0, {25'h0, blk_sel_ff});
    rd_at(1'b0, 22'h008001, 1'b0);
    chk_rd(1'b0, 8'h00, 1'b1);
    chk_val("blk", 32'h1, {25'h0, blk_sel_ff});
    rd_at(1'b1, 22'h3f8002, 1'b0);
    chk_rd(1'b1, 8'h01, 1'b1);
    chk_val("blk", 32'h7f, {25'h0, blk_sel_ff});
    go <= 1'b0;
    repeat (8) @(negedge mclk);
    chk_rd(1'b1, 8'h00, 1'b0);
    send(8'h00);
    chk_bit("qmode", 1'b1, query_mode_ff);
    foreach (lv[i]) begin
      send(lv[i]);
      chk_bit("qmode", 1'b0, query_mode_ff);
      rd_at(1'b1, 22'h10, 1'b0);
      chk_rd(1'b1, 8'h00, 1'b0);
      send(CMD_QUERY);
    end
    arst_n = 1'b0;
    @(negedge mclk);
    chk_rd(1'b1, 8'h00, 1'b0);
    arst_n = 1'b1;
    repeat (8) @(negedge mclk);
    chk_bit("qmode", 1'b0, query_mode_ff);
    chk_rd(1'b1, 8'h00, 1'b0);
    conclude();
  end
endmodule : qry_readout_tb
